// ==== rtl/cdl_io_regs.svh ====
// constants of the camera digital line block, with notes on behaviour
// Notes on behaviour
// - A line selector picks one physical pin or transport line to configure.
// - Each physical line can be set to input or to output.
// - A per-line inversion flips the line signal in both directions.
// - The logic state of the selected line is readable as one bit.
// - One word returns the level of every line, one bit each.
// - An output line carries the source signal chosen for it.
// - A bit selector picks one bit of the user output register.
// - A single-bit write stores into the selected bit; it reads back.
// - A whole word writes the bits enabled by the mask and reads the entire user output register.
// - A readable, writable mask is applied to whole-word writes.
`ifndef CDL_IO_REGS_SVH
`define CDL_IO_REGS_SVH

// line counts and register widths
`define CDL_N_PHYS       4
`define CDL_N_VIRT       4
`define CDL_N_ACQ        4
`define CDL_N_UOUT       8
`define CDL_SRC_W        4

// drive source codes: off, then acquisition signals, then user bits
`define CDL_SRC_OFF      4'h0
`define CDL_SRC_ACQ0     4'h1
`define CDL_SRC_USR0     4'h8

// reset values
`define CDL_MASK_RST_BIT 1'b1
`define CDL_UOUT_RST_BIT 1'b0

`endif

// ==== rtl/cdl_pkg.sv ====
// types shared by the camera digital line block
`include "cdl_io_regs.svh"

package cdl_pkg;

  // direction of one line
  typedef enum logic {
    CDL_DIR_IN,
    CDL_DIR_OUT
  } cdl_dir_e;

  // per-line configuration
  typedef struct packed {
    cdl_dir_e                  dir;
    logic                      flip;
    logic [`CDL_SRC_W-1:0]     src;
  } cdl_line_cfg_s;

endpackage : cdl_pkg

// ==== rtl/cdl_io.sv ====
// camera digital line block: line config, line status, user outputs
`timescale 1ns/10ps
`include "cdl_io_regs.svh"

module cdl_io #(
  parameter int N_PHYS = `CDL_N_PHYS,
  parameter int N_VIRT = `CDL_N_VIRT,
  parameter int N_ACQ  = `CDL_N_ACQ,
  parameter int N_UOUT = `CDL_N_UOUT
) (
  // clock and reset
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rstn,
  // line configuration
  input  wire logic [$clog2(N_PHYS+N_VIRT)-1:0] i_io_pin_pick,
  input  wire logic                        i_cfg_wr,
  input  wire logic                        i_pin_direction,
  input  wire logic                        i_pin_polarity_flip,
  input  wire logic [`CDL_SRC_W-1:0]       i_pin_drive_source,
  output logic                             o_pin_direction,
  output logic                             o_pin_polarity_flip,
  output logic [`CDL_SRC_W-1:0]            o_pin_drive_source,
  // line status
  output logic                             o_pin_level_read,
  output logic [N_PHYS+N_VIRT-1:0]         o_all_pins_level_word,
  // user output register
  input  wire logic [$clog2(N_UOUT)-1:0]   i_soft_out_bit_pick,
  input  wire logic                        i_soft_out_bit_wr,
  input  wire logic                        i_soft_out_bit,
  output logic                             o_soft_out_bit,
  input  wire logic                        i_soft_out_word_wr,
  input  wire logic [N_UOUT-1:0]           i_soft_out_word,
  output logic [N_UOUT-1:0]                o_soft_out_word,
  input  wire logic                        i_soft_out_mask_wr,
  input  wire logic [N_UOUT-1:0]           i_soft_out_write_mask,
  output logic [N_UOUT-1:0]                o_soft_out_write_mask,
  // internal acquisition signals, same clock
  input  wire logic [N_ACQ-1:0]            i_acq_sig,
  // connector pins
  input  wire logic [N_PHYS-1:0]           i_pin_in,
  output logic [N_PHYS-1:0]                o_pin_out,
  output logic [N_PHYS-1:0]                o_pin_oe,
  // transport layer virtual lines, same clock
  input  wire logic [N_VIRT-1:0]           i_tl_in,
  output logic [N_VIRT-1:0]                o_tl_out
);

  localparam int N_LINES = N_PHYS + N_VIRT;

  typedef struct packed {
    cdl_pkg::cdl_line_cfg_s [N_LINES-1:0] cfg;
    logic [N_PHYS-1:0]                   sync1;
    logic [N_PHYS-1:0]                   sync2;
    logic [N_PHYS-1:0]                   pin_out;
    logic [N_PHYS-1:0]                   pin_oe;
    logic [N_VIRT-1:0]                   tl_out;
    logic [N_UOUT-1:0]                   uout;
    logic [N_UOUT-1:0]                   mask;
    logic                                bit_rd;
    logic                                lvl_rd;
    logic [N_LINES-1:0]                  lvl_all;
    cdl_pkg::cdl_line_cfg_s              cfg_rd;
  } cdl_state_s;

  cdl_state_s           st_reg;
  cdl_state_s           st_next;
  logic [N_LINES-1:0]   in_all;
  logic [N_LINES-1:0]   drv;
  logic [N_LINES-1:0]   lvl;

  // value of a drive source code; unknown codes give a quiet low line
  function automatic logic cdl_src_value(
    input logic [`CDL_SRC_W-1:0] s,
    input logic [N_ACQ-1:0]      acq,
    input logic [N_UOUT-1:0]     usr
  );
    logic r;
    r = 1'b0;
    for (int k = 0; k < N_ACQ; k++) begin
      if (s == `CDL_SRC_W'(`CDL_SRC_ACQ0 + k)) begin
        r = acq[k];
      end
    end
    for (int k = 0; k < N_UOUT; k++) begin
      if (s == `CDL_SRC_W'(`CDL_SRC_USR0 + k)) begin
        r = usr[k];
      end
    end
    return r;
  endfunction : cdl_src_value

  // raw line inputs: synchronised pins low, transport lines high
  assign in_all = {i_tl_in, st_reg.sync2};

  // next state of the whole block
  always_comb begin
    st_next = st_reg;
    drv     = '0;
    lvl     = '0;
    // pins are asynchronous; the first stage feeds only the second
    st_next.sync1 = i_pin_in;
    st_next.sync2 = st_reg.sync1;
    if (i_cfg_wr) begin
      st_next.cfg[i_io_pin_pick].dir =
        cdl_pkg::cdl_dir_e'(i_pin_direction);
      st_next.cfg[i_io_pin_pick].flip = i_pin_polarity_flip;
      st_next.cfg[i_io_pin_pick].src  = i_pin_drive_source;
    end
    if (i_soft_out_word_wr) begin
      st_next.uout = (st_reg.uout & ~st_reg.mask) |
                     (i_soft_out_word & st_reg.mask);
    end
    // single bit write, wins over a word write on its bit
    if (i_soft_out_bit_wr) begin
      st_next.uout[i_soft_out_bit_pick] = i_soft_out_bit;
    end
    // mask store; a word written in the same cycle sees the old one
    if (i_soft_out_mask_wr) begin
      st_next.mask = i_soft_out_write_mask;
    end
    for (int k = 0; k < N_LINES; k++) begin
      drv[k] = cdl_src_value(st_reg.cfg[k].src, i_acq_sig, st_reg.uout);
      // inversion on input; status of outputs is the logical source
      if (st_reg.cfg[k].dir == cdl_pkg::CDL_DIR_OUT) begin
        lvl[k] = drv[k];
      end else begin
        lvl[k] = in_all[k] ^ st_reg.cfg[k].flip;
      end
    end
    for (int k = 0; k < N_PHYS; k++) begin
      st_next.pin_oe[k]  = (st_reg.cfg[k].dir == cdl_pkg::CDL_DIR_OUT);
      st_next.pin_out[k] = drv[k] ^ st_reg.cfg[k].flip;
    end
    // virtual lines idle low while set as inputs
    for (int k = 0; k < N_VIRT; k++) begin
      st_next.tl_out[k] =
        (st_reg.cfg[N_PHYS+k].dir == cdl_pkg::CDL_DIR_OUT) &&
        (drv[N_PHYS+k] ^ st_reg.cfg[N_PHYS+k].flip);
    end
    st_next.lvl_rd  = lvl[i_io_pin_pick];
    st_next.lvl_all = lvl;
    st_next.bit_rd  = st_reg.uout[i_soft_out_bit_pick];
    st_next.cfg_rd  = st_reg.cfg[i_io_pin_pick];
  end

  // state register; all lines come up as undriven inputs
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg      <= '0;
      st_reg.uout <= {N_UOUT{`CDL_UOUT_RST_BIT}};
      st_reg.mask <= {N_UOUT{`CDL_MASK_RST_BIT}};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign o_pin_direction       = st_reg.cfg_rd.dir;
  assign o_pin_polarity_flip   = st_reg.cfg_rd.flip;
  assign o_pin_drive_source    = st_reg.cfg_rd.src;
  assign o_pin_level_read      = st_reg.lvl_rd;
  assign o_all_pins_level_word = st_reg.lvl_all;
  assign o_soft_out_bit        = st_reg.bit_rd;
  assign o_soft_out_word       = st_reg.uout;
  assign o_soft_out_write_mask = st_reg.mask;
  assign o_pin_out             = st_reg.pin_out;
  assign o_pin_oe              = st_reg.pin_oe;
  assign o_tl_out              = st_reg.tl_out;

  // checks on the block's own behaviour
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  chk_cfg_write_lands: assert property (
    i_cfg_wr |=> st_reg.cfg[$past(i_io_pin_pick)].flip ==
                 $past(i_pin_polarity_flip))
    else $error("line config write not stored");

  chk_dir_drives_oe: assert property (
    ##1 o_pin_oe[0] ==
        ($past(st_reg.cfg[0].dir) == cdl_pkg::CDL_DIR_OUT))
    else $error("pin enable does not follow direction");

  chk_flip_output: assert property (
    ##1 o_pin_out[0] == ($past(drv[0]) ^ $past(st_reg.cfg[0].flip)))
    else $error("pin output not inverted as set");

  chk_status_pick: assert property (
    ##1 o_pin_level_read == $past(lvl[i_io_pin_pick]))
    else $error("selected line status wrong");

  chk_all_levels: assert property (
    ##1 o_all_pins_level_word == $past(lvl))
    else $error("all line word wrong");

  chk_user_source: assert property (
    (st_reg.cfg[0].src == `CDL_SRC_USR0) |-> drv[0] == st_reg.uout[0])
    else $error("user bit source not routed");

  chk_bit_write: assert property (
    i_soft_out_bit_wr |=> o_soft_out_word[$past(i_soft_out_bit_pick)]
                          == $past(i_soft_out_bit))
    else $error("user bit write lost");

  chk_bit_readback: assert property (
    $stable(i_soft_out_bit_pick) [*2] |->
      o_soft_out_bit == $past(o_soft_out_word[i_soft_out_bit_pick]))
    else $error("user bit readback wrong");

  chk_word_masked: assert property (
    i_soft_out_word_wr && !i_soft_out_bit_wr |=>
      o_soft_out_word == (($past(o_soft_out_word) &
      ~$past(o_soft_out_write_mask)) |
      ($past(i_soft_out_word) & $past(o_soft_out_write_mask))))
    else $error("masked word write wrong");

  chk_word_hold: assert property (
    !i_soft_out_word_wr && !i_soft_out_bit_wr |=> $stable(o_soft_out_word))
    else $error("user register changed without a write");

  chk_mask_store: assert property (
    i_soft_out_mask_wr |=> o_soft_out_write_mask ==
                           $past(i_soft_out_write_mask))
    else $error("mask write not stored");

  cov_partial_mask: cover property (
    i_soft_out_word_wr && (o_soft_out_write_mask != '0) &&
    (o_soft_out_write_mask != '1));
  cov_pin_toggles: cover property (o_pin_oe[0] ##1 $changed(o_pin_out[0]));
  cov_bit_write: cover property (i_soft_out_bit_wr ##1 i_soft_out_word_wr);
  cov_input_seen: cover property ($rose(o_all_pins_level_word[0]));

endmodule : cdl_io

// ==== bench/cdl_ext_equip.sv ====
// external equipment model wired to the connector lines
`timescale 1ns/10ps

module cdl_ext_equip (
  // block side of the connector
  input  wire logic [3:0] i_pin_out,
  input  wire logic [3:0] i_pin_oe,
  // level the equipment puts on undriven lines
  input  wire logic [3:0] i_ext_level,
  output logic      [3:0] o_pin_in
);
  // wire level: the block wins where it drives, else the equipment drives
  assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_level);
endmodule : cdl_ext_equip

// ==== bench/test_camera_digital_line_io.sv ====
// self-checking bench for the camera digital line block
`timescale 1ns/10ps

module test_camera_digital_line_io;
  logic       clk, rstn, cfg_wr, dir, flip, bwr, bdat, wwr, mwr;
  logic       dir_q, flip_q, lvl_q, bit_q;
  logic [2:0] pick, bpick;
  logic [3:0] src, src_q, acq, tl_in, tl_out, pin_in, pin_out, pin_oe, ext;
  logic [7:0] wdat, mdat, all_w, word_q, mask_q;
  int         mismatches, n_compared;

  cdl_io uut (.i_sys_clk(clk), .i_rstn(rstn), .i_io_pin_pick(pick),
    .i_cfg_wr(cfg_wr), .i_pin_direction(dir), .i_pin_polarity_flip(flip),
    .i_pin_drive_source(src), .o_pin_direction(dir_q),
    .o_pin_polarity_flip(flip_q), .o_pin_drive_source(src_q),
    .o_pin_level_read(lvl_q), .o_all_pins_level_word(all_w),
    .i_soft_out_bit_pick(bpick), .i_soft_out_bit_wr(bwr),
    .i_soft_out_bit(bdat), .o_soft_out_bit(bit_q),
    .i_soft_out_word_wr(wwr), .i_soft_out_word(wdat),
    .o_soft_out_word(word_q), .i_soft_out_mask_wr(mwr),
    .i_soft_out_write_mask(mdat), .o_soft_out_write_mask(mask_q),
    .i_acq_sig(acq), .i_pin_in(pin_in), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .i_tl_in(tl_in), .o_tl_out(tl_out));

  cdl_ext_equip ext_eq (.i_pin_out(pin_out), .i_pin_oe(pin_oe),
    .i_ext_level(ext), .o_pin_in(pin_in));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk

  // one-cycle config pulse, then let sync and readback settle
  task cfg(input logic [2:0] p, input logic d, f, input logic [3:0] s);
    pick = p; dir = d; flip = f; src = s; cfg_wr = 1'b1;
    step(1);
    cfg_wr = 1'b0;
    step(4);
  endtask : cfg

  task t_reset;
    chk({dir_q, flip_q, src_q, pin_oe[1:0]}, 8'h00, "reset config");
    chk(mask_q, 8'hFF, "reset mask");
    chk(word_q, 8'h00, "reset user word");
  endtask : t_reset

  // user bit 0 routed to pin 0, then inverted at the pin only
  task t_out;
    bpick = 3'h0; bdat = 1'b1; bwr = 1'b1;
    step(1);
    bwr = 1'b0;
    cfg(3'h0, 1'b1, 1'b0, 4'h8);
    chk({pin_oe[0], pin_out[0], dir_q, lvl_q, src_q},
        8'hF8, "out line");
    cfg(3'h0, 1'b1, 1'b1, 4'h8);
    chk({pin_out[0], flip_q, lvl_q, bit_q}, 8'h07, "inverted out");
  endtask : t_out

  // inverted physical input, plain transport input, inverted transport out
  task t_in;
    ext = 4'h2; tl_in = 4'h2;
    cfg(3'h1, 1'b0, 1'b1, 4'h0);
    chk({pin_oe[1], lvl_q, all_w[1]}, 8'h00, "inverted input");
    cfg(3'h5, 1'b0, 1'b0, 4'h0);
    chk({lvl_q, all_w[5], tl_out[1]}, 8'h06, "transport input");
    // source off drives low; the flip makes the virtual line high
    cfg(3'h6, 1'b1, 1'b1, 4'h0);
    chk({dir_q, lvl_q, all_w[6], tl_out[2]}, 8'h09, "transport out");
  endtask : t_in

  task t_acq;
    acq = 4'h2;
    cfg(3'h2, 1'b1, 1'b0, 4'h2);
    chk(pin_out[2], 1'b1, "acq high");
    acq = 4'h0;
    step(2);
    chk(pin_out[2], 1'b0, "acq low");
  endtask : t_acq

  // masked whole-word writes leave unmasked bits alone
  task t_mask;
    mdat = 8'h0F; mwr = 1'b1;
    step(1);
    mwr = 1'b0; wdat = 8'hFF; wwr = 1'b1;
    step(1);
    wwr = 1'b0; mdat = 8'hF0; mwr = 1'b1;
    step(1);
    mwr = 1'b0;
    chk(word_q, 8'h0F, "masked set");
    wdat = 8'h00; wwr = 1'b1;
    step(1);
    wwr = 1'b0; bpick = 3'h3;
    step(2);
    chk(mask_q, 8'hF0, "mask readback");
    chk(word_q, 8'h0F, "masked clear");
    chk(bit_q, 1'b1, "bit read");
  endtask : t_mask

  task end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // watchdog well beyond the fifty or so cycles the tests need
  initial begin
    #(4000 * 40);
    mismatches++;
    end_of_test();
  end

  initial begin
    {rstn, cfg_wr, dir, flip, bwr, bdat, wwr, mwr} = '0;
    {pick, bpick, src, acq, tl_in, ext, wdat, mdat} = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    step(1);
    t_reset();
    t_out();
    t_in();
    t_acq();
    t_mask();
    end_of_test();
  end
endmodule : test_camera_digital_line_io
